//--- src/scch_top.sv
`timescale 1ns/1ps
// How it works
// - Serial rate accepted only from ten supported values; factory rate 115200.
// - Unsupported rate request leaves rate unchanged; host should request supported ones.
// - Packet size held in bytes, 1 to 1400 accepted, default 1400.
// - Flush timeout held in ms, 0 to 50 accepted, default 10.
// - Set commands write storage; values take effect only at next restart.
// - Live status query reports active settings and state, not stored ones.
// - Serial query reports stored rate, packet size and timeout.
// - Restore-defaults command returns every stored setting to factory values.
// - Factory-default pin toggled in sequence also restores factory settings.
// - Factory state has hardware and software flow control off.
module scch_top import scch_pkg::*; #(
  parameter int MS_CYC    = MS_CYCLES,   // Clock cycles per millisecond
  parameter int FDEF_EDGES = FDEF_TOGGLE // Pin rises that restore defaults
) (
  input  wire logic             CLOCK,     // 200 MHz clock
  input  wire logic             NRST,      // Async reset, low
  input  wire logic             RESTART,   // Soft restart pulse
  input  wire logic             CMD_VALID, // Decoded command strobe
  input  wire logic [2:0]       CMD_OP,    // Command code
  input  wire logic [ARG_W-1:0] CMD_ARG,   // Numeric argument
  input  wire logic             FDEF_PIN,  // Factory-default pin
  input  wire logic             RX_VALID,  // Serial data byte strobe
  input  wire logic [7:0]       RX_BYTE,   // Serial data byte
  output logic                  CMD_READY, // Command accepted when high
  output logic                  RSP_VALID, // Ack byte strobe
  output logic [7:0]            RSP_BYTE,  // Ack byte
  output logic                  STAT_VALID,// Query answer strobe
  output scch_stat_t            STAT,      // Query answer
  output scch_cfg_t             ACTIVE,    // Settings in use
  output logic                  FLOW_EN,   // Flow control in use
  output logic                  TX_VALID,  // Byte to wireless
  output logic [7:0]            TX_BYTE,   // Byte data
  output logic                  TX_LAST    // Closes a packet
);
  // Edge counter is four bits wide, so more than 15 rises cannot be counted
  if (MS_CYC < 1 || FDEF_EDGES < 1 || FDEF_EDGES > 15) begin : g_bad_param
    $error("Bad scch_top parameters");
  end

  localparam int DIV_W = $clog2(MS_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(MS_CYC - 1);
  localparam logic [10:0] FWIN = 11'(FDEF_WIN_MS);
  localparam logic [3:0]  FTOP = 4'(FDEF_EDGES);

  scch_cfg_t   stored_q;
  scch_rsp_t   rs_q, rs_d;
  logic        ok_q;
  logic [DIV_W-1:0] div_q;
  logic        ms_tick_q;
  logic        pin_q;
  logic [3:0]  fcnt_q;
  logic [10:0] fwin_q;

  // Rate lookup, one comparator per table entry
  logic [BAUD_COUNT-1:0] baud_hit;
  logic [3:0]            baud_idx;
  genvar g;
  generate
    for (g = 0; g < BAUD_COUNT; g++) begin : g_baud
      assign baud_hit[g] = (CMD_ARG == BAUD_TABLE[g]);
    end
  endgenerate
  always_comb begin
    baud_idx = 4'h0;
    for (int i = 0; i < BAUD_COUNT; i++)
      if (baud_hit[i]) baud_idx = 4'(i);
  end

  wire take      = CMD_VALID && CMD_READY;
  wire is_baud   = take && CMD_OP == OP_SET_BAUD;
  wire is_mtu    = take && CMD_OP == OP_SET_MTU;
  wire is_flush  = take && CMD_OP == OP_SET_FLUSH;
  wire is_dflt   = take && CMD_OP == OP_DEFAULTS;
  wire is_live   = take && CMD_OP == OP_GET_STATE;
  wire is_uart   = take && CMD_OP == OP_GET_UART;
  wire baud_ok   = |baud_hit;
  wire mtu_ok    = CMD_ARG >= ARG_W'(MTU_MIN) && CMD_ARG <= ARG_W'(MTU_MAX);
  wire flush_ok  = CMD_ARG <= ARG_W'(FLUSH_MAX);
  wire is_set    = is_baud || is_mtu || is_flush || is_dflt;
  wire set_ok    = is_dflt || (is_baud && baud_ok) || (is_mtu && mtu_ok) ||
                   (is_flush && flush_ok);
  wire pin_rise  = FDEF_PIN && !pin_q;
  wire pin_fdef  = pin_rise && (fcnt_q + 4'h1 >= FTOP);
  wire do_fact   = is_dflt || pin_fdef;

  assign rs_d = (rs_q == RS_IDLE) ? (is_set ? RS_B0 : RS_IDLE) :
                (rs_q == RS_B0)   ? RS_B1 :
                (rs_q == RS_B1)   ? RS_B2 : RS_IDLE;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      div_q     <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (div_q == DIV_TOP);
      div_q     <= (div_q == DIV_TOP) ? '0 : div_q + 1'b1;
    end
  end

  // Stored settings model the non-volatile copy
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      stored_q <= CFG_FACTORY;
    end else if (do_fact) begin
      stored_q <= CFG_FACTORY;
    end else begin
      if (is_baud && baud_ok) stored_q.baud_idx <= baud_idx;
      if (is_mtu && mtu_ok) stored_q.mtu <= CMD_ARG[10:0];
      if (is_flush && flush_ok) stored_q.flush_ms <= CMD_ARG[5:0];
    end
  end

  // Live settings change only on restart
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ACTIVE  <= CFG_FACTORY;
      FLOW_EN <= FLOW_DEF;
    end else if (RESTART) begin
      ACTIVE  <= stored_q;
      FLOW_EN <= FLOW_DEF;
    end
  end

  // Factory pin: count rises, window restarts at each rise
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_q  <= 1'b0;
      fcnt_q <= 4'h0;
      fwin_q <= 11'h000;
    end else begin
      pin_q <= FDEF_PIN;
      if (pin_rise) begin
        fcnt_q <= pin_fdef ? 4'h0 : fcnt_q + 4'h1;
        fwin_q <= 11'h000;
      end else if (ms_tick_q && fcnt_q != 4'h0) begin
        fwin_q <= fwin_q + 11'h001;
        if (fwin_q + 11'h001 >= FWIN) fcnt_q <= 4'h0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rs_q       <= RS_IDLE;
      ok_q       <= 1'b0;
      CMD_READY  <= 1'b1;
      RSP_VALID  <= 1'b0;
      RSP_BYTE   <= 8'h00;
      STAT_VALID <= 1'b0;
      STAT       <= '0;
    end else begin
      rs_q       <= rs_d;
      CMD_READY  <= (rs_d == RS_IDLE);
      if (rs_q == RS_IDLE && is_set) ok_q <= set_ok;
      RSP_VALID  <= (rs_q != RS_IDLE);
      case (rs_q)
        RS_B0:   RSP_BYTE <= ok_q ? CH_O : CH_E;
        RS_B1:   RSP_BYTE <= ok_q ? CH_K : CH_R;
        RS_B2:   RSP_BYTE <= CH_CR;
        default: RSP_BYTE <= 8'h00;
      endcase
      STAT_VALID <= is_live || is_uart;
      if (is_live) STAT <= '{1'b1, FLOW_EN, ACTIVE};
      if (is_uart) STAT <= '{1'b0, FLOW_EN, stored_q};
    end
  end

  scch_forward u_scch_forward (
    .clk      (CLOCK),
    .nrst     (NRST),
    .ms_tick  (ms_tick_q),
    .mtu      (ACTIVE.mtu),
    .flush_ms (ACTIVE.flush_ms),
    .rx_valid (RX_VALID),
    .rx_byte  (RX_BYTE),
    .tx_valid (TX_VALID),
    .tx_byte  (TX_BYTE),
    .tx_last  (TX_LAST)
  );

  bad_baud_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    is_baud && !baud_ok && !pin_fdef |=> $stable(stored_q.baud_idx))
    else $error("Unsupported rate changed setting");
  rate_range_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    stored_q.baud_idx < 4'(BAUD_COUNT))
    else $error("Stored rate out of table");
  mtu_range_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    stored_q.mtu >= MTU_MIN && stored_q.mtu <= MTU_MAX)
    else $error("Packet size out of range");
  flush_range_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    stored_q.flush_ms <= FLUSH_MAX)
    else $error("Flush timeout out of range");
  no_early_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    !RESTART |=> $stable(ACTIVE))
    else $error("Active settings changed without restart");
  live_stat_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    is_live |=> STAT_VALID && STAT.live && STAT.cfg == $past(ACTIVE))
    else $error("Live query wrong");
  uart_stat_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    is_uart |=> STAT_VALID && !STAT.live && STAT.cfg == $past(stored_q))
    else $error("Stored query wrong");
  dflt_cmd_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    do_fact |=> stored_q == CFG_FACTORY)
    else $error("Defaults not restored");
  flow_off_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    !FLOW_EN)
    else $error("Flow control enabled");
  ack_cr_a: assert property (@(posedge CLOCK) disable iff (!NRST)
    is_set |=> ##1 RSP_VALID ##1 RSP_VALID ##1 RSP_VALID && RSP_BYTE == CH_CR)
    else $error("Ack string not ended by carriage return");
endmodule

//--- src/scch_pkg.sv
package scch_pkg;
  // Command codes on the decoded command port
  localparam logic [2:0] OP_SET_BAUD   = 3'h0;
  localparam logic [2:0] OP_SET_MTU    = 3'h1;
  localparam logic [2:0] OP_SET_FLUSH  = 3'h2;
  localparam logic [2:0] OP_GET_STATE  = 3'h3;
  localparam logic [2:0] OP_GET_UART   = 3'h4;
  localparam logic [2:0] OP_DEFAULTS   = 3'h5;

  localparam int         BAUD_COUNT    = 10;
  localparam int         ARG_W         = 20;
  localparam logic [19:0] BAUD_TABLE [BAUD_COUNT] = '{
    20'h00960, 20'h012C0, 20'h02580, 20'h04B00, 20'h09600,
    20'h0E100, 20'h1C200, 20'h38400, 20'h70800, 20'hE1000};
  localparam logic [3:0]  BAUD_IDX_DEF = 4'h6;    // 115200
  localparam logic [10:0] MTU_MIN      = 11'h001;
  localparam logic [10:0] MTU_MAX      = 11'h578; // 1400
  localparam logic [10:0] MTU_DEF      = 11'h578;
  localparam logic [5:0]  FLUSH_MAX    = 6'h32;   // 50 ms
  localparam logic [5:0]  FLUSH_DEF    = 6'h0A;   // 10 ms
  localparam logic        FLOW_DEF     = 1'b0;

  // Ack strings: OK<cr> on accept, ER<cr> on a refused value
  localparam logic [7:0] CH_O  = 8'h4F;
  localparam logic [7:0] CH_K  = 8'h4B;
  localparam logic [7:0] CH_E  = 8'h45;
  localparam logic [7:0] CH_R  = 8'h52;
  localparam logic [7:0] CH_CR = 8'h0D;

  localparam int CLK_HZ      = 200_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int MS_CYCLES   = CLK_HZ / MS_PER_S;
  localparam int FDEF_TOGGLE = 3;
  localparam int FDEF_WIN_MS = 1000;

  typedef struct packed {
    logic [3:0]  baud_idx;
    logic [10:0] mtu;
    logic [5:0]  flush_ms;
  } scch_cfg_t;

  typedef struct packed {
    logic      live;
    logic      flow_en;
    scch_cfg_t cfg;
  } scch_stat_t;

  localparam scch_cfg_t CFG_FACTORY = '{BAUD_IDX_DEF, MTU_DEF, FLUSH_DEF};

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_B0   = 2'b01,
    RS_B1   = 2'b11,
    RS_B2   = 2'b10
  } scch_rsp_t;
endpackage

//--- src/scch_forward.sv
`timescale 1ns/1ps
module scch_forward import scch_pkg::*; (
  input  wire logic        clk,      // System clock
  input  wire logic        nrst,     // Async reset, low
  input  wire logic        ms_tick,  // One pulse per millisecond
  input  wire logic [10:0] mtu,      // Active packet size
  input  wire logic [5:0]  flush_ms, // Active flush timeout
  input  wire logic        rx_valid, // Serial byte strobe
  input  wire logic [7:0]  rx_byte,  // Serial byte
  output logic             tx_valid, // Byte to wireless
  output logic [7:0]       tx_byte,  // Byte data
  output logic             tx_last   // Closes a packet
);
  logic        hold_v_q;
  logic [7:0]  hold_b_q;
  logic [10:0] cnt_q;
  logic        seal_q;
  logic [5:0]  idle_q;
  // One byte held back so the packet end can be marked on the last byte
  wire         tmo     = hold_v_q && !seal_q && (idle_q >= flush_ms);
  wire         close   = hold_v_q && (seal_q || tmo);
  wire         emit    = hold_v_q && (rx_valid || close);
  wire  [10:0] cnt_nx  = (close ? 11'h000 : cnt_q) + 11'h001;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_v_q <= 1'b0;
      hold_b_q <= 8'h00;
      cnt_q    <= 11'h000;
      seal_q   <= 1'b0;
      idle_q   <= 6'h00;
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      tx_last  <= 1'b0;
    end else begin
      tx_valid <= emit;
      tx_byte  <= hold_b_q;
      tx_last  <= close;
      if (rx_valid) begin
        hold_v_q <= 1'b1;
        hold_b_q <= rx_byte;
        cnt_q    <= cnt_nx;
        seal_q   <= (cnt_nx >= mtu);
        idle_q   <= 6'h00;
      end else if (close) begin
        hold_v_q <= 1'b0;
        cnt_q    <= 11'h000;
        seal_q   <= 1'b0;
      end else if (ms_tick && idle_q != FLUSH_MAX) begin
        idle_q   <= idle_q + 6'h01;
      end
    end
  end

  size_close_a: assert property (@(posedge clk) disable iff (!nrst)
    seal_q && hold_v_q |=> tx_valid && tx_last)
    else $error("Full packet not closed");
  timeout_close_a: assert property (@(posedge clk) disable iff (!nrst)
    hold_v_q && !rx_valid && !seal_q && idle_q >= flush_ms |=> tx_last)
    else $error("Flush timeout not honoured");
endmodule

//--- verif/scch_host.sv
`timescale 1ns/1ps
module scch_host import scch_pkg::*; (
  input  wire logic        clk,       // System clock
  input  wire logic        ready,     // Command may be given
  output logic             cmd_valid, // Command strobe
  output logic [2:0]       cmd_op,    // Command code
  output logic [ARG_W-1:0] cmd_arg,   // Numeric argument
  output logic             fdef_pin,  // Factory-default pin
  output logic             rx_valid,  // Serial byte strobe
  output logic [7:0]       rx_byte    // Serial byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h7;
    cmd_arg = 20'h5A5A5;
    fdef_pin = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'hA5;
  end
  // Ready is looked at mid-cycle, so the request never races its update
  task automatic cmd(input logic [2:0] op, input logic [ARG_W-1:0] arg);
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg <= arg;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_op <= ~op;
    cmd_arg <= ~arg; // Released lines never keep the old value
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      fdef_pin <= ~fdef_pin;
      repeat (3) @(posedge clk);
      fdef_pin <= ~fdef_pin;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

//--- verif/test_serial_config_command_handler.sv
`timescale 1ns/1ps
module test_serial_config_command_handler import scch_pkg::*;;
  localparam logic [23:0] OK_S = {CH_O, CH_K, CH_CR};
  localparam logic [23:0] ER_S = {CH_E, CH_R, CH_CR};
  logic             CLOCK, NRST, RESTART, CMD_VALID, FDEF_PIN, RX_VALID;
  logic [2:0]       CMD_OP;
  logic [ARG_W-1:0] CMD_ARG;
  logic [7:0]       RX_BYTE, RSP_BYTE, TX_BYTE;
  logic             CMD_READY, RSP_VALID, STAT_VALID, FLOW_EN, TX_VALID, TX_LAST;
  scch_stat_t       STAT;
  scch_cfg_t        ACTIVE;
  logic [8:0]       txq [$];
  int               n_fail = 0, n_compared = 0, cycles = 0;
  scch_top #(.MS_CYC(10)) u_scch_top (.CLOCK(CLOCK), .NRST(NRST), .RESTART(RESTART),
    .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ARG(CMD_ARG), .FDEF_PIN(FDEF_PIN),
    .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .CMD_READY(CMD_READY),
    .RSP_VALID(RSP_VALID), .RSP_BYTE(RSP_BYTE), .STAT_VALID(STAT_VALID), .STAT(STAT),
    .ACTIVE(ACTIVE), .FLOW_EN(FLOW_EN), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
    .TX_LAST(TX_LAST));
  scch_host u_scch_host (.clk(CLOCK), .ready(CMD_READY), .cmd_valid(CMD_VALID),
    .cmd_op(CMD_OP), .cmd_arg(CMD_ARG), .fdef_pin(FDEF_PIN), .rx_valid(RX_VALID),
    .rx_byte(RX_BYTE));
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  always @(negedge CLOCK) if (TX_VALID === 1'b1) txq.push_back({TX_LAST, TX_BYTE});
  task automatic results;
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Queries expect no ack bytes, so exp is zero for them
  task automatic run(input logic [2:0] op, input logic [ARG_W-1:0] arg,
                     input logic [23:0] exp);
    logic [23:0] rsp;
    int          n_st;
    int          n_low;
    rsp = 24'h000000;
    n_st = 0;
    n_low = 0;
    u_scch_host.cmd(op, arg);
    repeat (8) begin
      @(negedge CLOCK);
      if (RSP_VALID === 1'b1) rsp = {rsp[15:0], RSP_BYTE};
      if (STAT_VALID === 1'b1) n_st++;
      if (CMD_READY !== 1'b1) n_low++;
    end
    chk(rsp, exp);
    chk(n_st, (op == OP_GET_STATE || op == OP_GET_UART) ? 1 : 0);
    chk(n_low, (exp != 24'h000000) ? 3 : 0);
  endtask
  task automatic restart;
    @(posedge CLOCK);
    RESTART <= ~RESTART;
    @(posedge CLOCK);
    RESTART <= ~RESTART;
    @(negedge CLOCK);
  endtask
  task automatic t_reset;
    chk(ACTIVE, CFG_FACTORY);
    chk(FLOW_EN, 1'b0);
    run(OP_GET_STATE, 20'h00000, 24'h000000);
    chk({STAT.live, STAT.flow_en}, 2'b10);
  endtask
  task automatic t_baud;
    for (int i = 0; i < BAUD_COUNT; i++) begin
      run(OP_SET_BAUD, BAUD_TABLE[i], OK_S);
      run(OP_GET_UART, 20'h00000, 24'h000000);
      chk({STAT.live, STAT.cfg.baud_idx}, {1'b0, 4'(i)});
    end
    run(OP_SET_BAUD, 20'h004D2, ER_S);
    run(OP_GET_UART, 20'h00000, 24'h000000);
    chk(STAT.cfg.baud_idx, 4'h9);
  endtask
  task automatic t_ranges;
    logic [2:0]  op [7] = '{OP_SET_MTU, OP_SET_MTU, OP_SET_MTU, OP_SET_MTU,
                            OP_SET_FLUSH, OP_SET_FLUSH, OP_SET_FLUSH};
    int          arg [7] = '{1400, 1, 0, 1401, 50, 0, 51};
    logic        ok;
    logic [16:0] exp;
    exp = {11'd1400, 6'd10};
    for (int i = 0; i < 7; i++) begin
      ok = (op[i] == OP_SET_MTU) ? (arg[i] >= 1 && arg[i] <= 1400) : (arg[i] <= 50);
      if (ok && op[i] == OP_SET_MTU) exp[16:6] = 11'(arg[i]);
      if (ok && op[i] == OP_SET_FLUSH) exp[5:0] = 6'(arg[i]);
      run(op[i], 20'(arg[i]), ok ? OK_S : ER_S);
      run(OP_GET_UART, 20'h00000, 24'h000000);
      chk({STAT.cfg.mtu, STAT.cfg.flush_ms}, exp);
    end
  endtask
  task automatic t_restart;
    chk(ACTIVE, CFG_FACTORY);
    run(OP_GET_STATE, 20'h00000, 24'h000000);
    chk(STAT.cfg, CFG_FACTORY);
    restart;
    chk(ACTIVE, {4'h9, 11'h001, 6'h00});
    run(OP_GET_STATE, 20'h00000, 24'h000000);
    chk(STAT.cfg, {4'h9, 11'h001, 6'h00});
  endtask
  task automatic t_forward;
    run(OP_SET_MTU, 20'h00003, OK_S);
    run(OP_SET_FLUSH, 20'h00002, OK_S);
    restart;
    txq.delete();
    u_scch_host.send(8'hA1);
    u_scch_host.send(8'hA2);
    u_scch_host.send(8'hA3);
    u_scch_host.send(8'hB1);
    repeat (5) @(negedge CLOCK);
    chk(txq.size(), 3);
    repeat (40) @(negedge CLOCK);
    chk(txq.size(), 4);
    chk({txq[0], txq[1], txq[2], txq[3]}, {9'h0A1, 9'h0A2, 9'h1A3, 9'h1B1});
  endtask
  task automatic t_defaults;
    run(3'h6, 20'h00001, 24'h000000);
    run(3'h7, 20'h00002, 24'h000000);
    run(OP_DEFAULTS, 20'h00000, OK_S);
    run(OP_GET_UART, 20'h00000, 24'h000000);
    chk(STAT.cfg, CFG_FACTORY);
  endtask
  task automatic t_pin;
    run(OP_SET_MTU, 20'h00007, OK_S);
    u_scch_host.toggle(FDEF_TOGGLE - 1);
    run(OP_GET_UART, 20'h00000, 24'h000000);
    chk(STAT.cfg.mtu, 11'h007);
    u_scch_host.toggle(1);
    run(OP_GET_UART, 20'h00000, 24'h000000);
    chk(STAT.cfg, CFG_FACTORY);
  endtask
  // Second reset in mid-run: everything back to its reset state
  task automatic t_nrst;
    run(OP_SET_MTU, 20'h00009, OK_S);
    restart;
    chk(ACTIVE.mtu, 11'h009);
    @(posedge CLOCK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    @(negedge CLOCK);
    chk(ACTIVE, CFG_FACTORY);
    chk({CMD_READY, RSP_VALID, STAT_VALID, TX_VALID, FLOW_EN}, 5'h10);
    run(OP_GET_UART, 20'h00000, 24'h000000);
    chk(STAT.cfg, CFG_FACTORY);
  endtask
  // Whole run is about 600 cycles; the ceiling leaves wide margin
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    NRST = 1'b0;
    RESTART = 1'b0;
    repeat (6) @(posedge CLOCK);
    NRST <= 1'b1;
    t_reset;
    t_baud;
    t_ranges;
    t_restart;
    t_forward;
    t_defaults;
    t_pin;
    t_nrst;
    results;
  end
endmodule
